/* rtl/rivm_defs.vh */
/*
 * Constants for the reset and interrupt vector map: table offsets,
 * address width, reset value and fuse polarity.
 * Assumes inclusion by bare name from the rtl files.
 */
`ifndef RIVM_DEFS_VH
`define RIVM_DEFS_VH

`define RIVM_ADDR_W 12
`define RIVM_SRC_N 25
`define RIVM_RESET_ADDR 12'h000
`define RIVM_TABLE_BASE 12'h001
`define RIVM_FUSE_PROGRAMMED 1'b0
`define RIVM_BOOT_ADDR_DEF 12'hc00

`define RIVM_OFS_EXT0 5'h01
`define RIVM_OFS_EXT1 5'h02
`define RIVM_OFS_PC0 5'h03
`define RIVM_OFS_PC1 5'h04
`define RIVM_OFS_PC2 5'h05
`define RIVM_OFS_WDOG 5'h06
`define RIVM_OFS_T2_MA 5'h07
`define RIVM_OFS_T2_MB 5'h08
`define RIVM_OFS_T2_WRAP 5'h09
`define RIVM_OFS_T1_CAP 5'h0a
`define RIVM_OFS_T1_MA 5'h0b
`define RIVM_OFS_T1_MB 5'h0c
`define RIVM_OFS_T1_WRAP 5'h0d
`define RIVM_OFS_T0_MA 5'h0e
`define RIVM_OFS_T0_MB 5'h0f
`define RIVM_OFS_T0_WRAP 5'h10
`define RIVM_OFS_SSER 5'h11
`define RIVM_OFS_ARX 5'h12
`define RIVM_OFS_ATXE 5'h13
`define RIVM_OFS_ATXC 5'h14
`define RIVM_OFS_CONV 5'h15
`define RIVM_OFS_NVM 5'h16
`define RIVM_OFS_ACMP 5'h17
`define RIVM_OFS_TWS 5'h18
`define RIVM_OFS_STORE 5'h19

`endif

/* rtl/rivm_offset_enc.v */
/*
 * Encodes a one-hot accepted-source vector into its table offset.
 * Bit i of the vector is the source at offset i+1; the lowest set bit wins.
 * Assumes at most one bit is set in normal use.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rivm_defs.vh"

module rivm_offset_enc #(
    parameter SRC_N = `RIVM_SRC_N
) (
    input wire [SRC_N-1:0] src,
    output reg [4:0] offset,
    output reg hit
);
    integer i;
    always @* begin
        offset = 5'h00;
        hit = 1'b0;
        // scan downward so the lowest index ends up winning
        for (i = SRC_N - 1; i >= 0; i = i - 1) begin
            if (src[i]) begin
                offset = i[4:0] + 5'h01;
                hit = 1'b1;
            end
        end
    end
endmodule // rivm_offset_enc

`default_nettype wire

/* rtl/rivm_vector_map.v */
/*
 * Reset and interrupt vector map: produces the program-counter load
 * address after reset and on each accepted interrupt.
 * Assumes the core presents one accepted source at a time (priority and
 * masking live elsewhere) and all inputs are synchronous to clock.
 * The boot section start is a level input; deriving it from the boot
 * size setting is left to the surrounding logic.
 * Data path: irq_accept is gated off during the reset load, the small
 * encoder turns the lowest set bit into a one-based slot, and the slot
 * indexes a table of offsets kept as header constants, so a part with
 * another table order only touches the header.
 * Several bits at once are not an error: the lowest one wins and the
 * others are dropped without trace, so the core must hold them itself.
 * A request in the cycle right after reset release is refused the same
 * way; the reset load always comes first.
 * Back-to-back requests give back-to-back loads; nothing is queued.
 * Outputs are registered; pc_load_q stands one cycle while the address
 * and the offset hold until the next load.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rivm_defs.vh"

module rivm_vector_map #(
    parameter ADDR_W = `RIVM_ADDR_W,
    parameter SRC_N = `RIVM_SRC_N
) (
    input wire clock,
    input wire rst_n,
    input wire boot_reset_vector_fuse,
    input wire vector_table_select,
    input wire [ADDR_W-1:0] boot_reset_addr,
    input wire [SRC_N-1:0] irq_accept,
    output reg [ADDR_W-1:0] pc_load_addr_q,
    output reg pc_load_q,
    output reg [4:0] vector_offset_q
);
    // bit order of irq_accept follows the table, offset 0x001 first
    localparam ST_RESET = 1'b0;
    localparam ST_RUN = 1'b1;
    localparam [4:0] NO_OFFSET = 5'h00;
    localparam [0:0] FUSE_PROG = `RIVM_FUSE_PROGRAMMED;
    // base stays at zero; one-based offsets give the 0x001 table start
    localparam [ADDR_W-1:0] RESET_TARGET = `RIVM_RESET_ADDR;

    // external requests zero and one
    // external pin zero
    localparam [4:0] OFS_EXT0 = `RIVM_OFS_EXT0;
    // external pin one
    localparam [4:0] OFS_EXT1 = `RIVM_OFS_EXT1;

    // pin-change groups, then watchdog
    // pin-change group zero
    localparam [4:0] OFS_PC0 = `RIVM_OFS_PC0;
    // pin-change group one
    localparam [4:0] OFS_PC1 = `RIVM_OFS_PC1;
    // pin-change group two
    localparam [4:0] OFS_PC2 = `RIVM_OFS_PC2;
    // watchdog time-out in interrupt mode
    localparam [4:0] OFS_WDOG = `RIVM_OFS_WDOG;

    // timer two
    // timer two match a
    localparam [4:0] OFS_T2_MA = `RIVM_OFS_T2_MA;
    // timer two match b
    localparam [4:0] OFS_T2_MB = `RIVM_OFS_T2_MB;
    // timer two wrap
    localparam [4:0] OFS_T2_WRAP = `RIVM_OFS_T2_WRAP;

    // timer one
    // timer one capture
    localparam [4:0] OFS_T1_CAP = `RIVM_OFS_T1_CAP;
    // timer one match a
    localparam [4:0] OFS_T1_MA = `RIVM_OFS_T1_MA;
    // timer one match b
    localparam [4:0] OFS_T1_MB = `RIVM_OFS_T1_MB;
    // timer one wrap
    localparam [4:0] OFS_T1_WRAP = `RIVM_OFS_T1_WRAP;

    // timer zero
    // timer zero match a
    localparam [4:0] OFS_T0_MA = `RIVM_OFS_T0_MA;
    // timer zero match b
    localparam [4:0] OFS_T0_MB = `RIVM_OFS_T0_MB;
    // timer zero wrap
    localparam [4:0] OFS_T0_WRAP = `RIVM_OFS_T0_WRAP;

    // serial units
    // sync serial done
    localparam [4:0] OFS_SSER = `RIVM_OFS_SSER;
    // async receive complete
    localparam [4:0] OFS_ARX = `RIVM_OFS_ARX;
    // async transmit buffer empty
    localparam [4:0] OFS_ATXE = `RIVM_OFS_ATXE;
    // async transmit done
    localparam [4:0] OFS_ATXC = `RIVM_OFS_ATXC;

    // converter, memories, comparator, two-wire
    // converter conversion complete
    localparam [4:0] OFS_CONV = `RIVM_OFS_CONV;
    // data nvm ready
    localparam [4:0] OFS_NVM = `RIVM_OFS_NVM;
    // analog comparator
    localparam [4:0] OFS_ACMP = `RIVM_OFS_ACMP;
    // two-wire serial event
    localparam [4:0] OFS_TWS = `RIVM_OFS_TWS;
    // program store ready
    localparam [4:0] OFS_STORE = `RIVM_OFS_STORE;

    // sequencing
    reg state_q;
    reg state_d;

    // source path
    wire [SRC_N-1:0] src_live;
    wire [4:0] enc_slot;
    wire enc_hit;
    wire [SRC_N*5-1:0] tab_term;
    reg [4:0] tab_offset;
    integer j;
    genvar g;

    // address path
    reg [ADDR_W-1:0] reset_addr;
    reg [ADDR_W-1:0] table_start;
    reg [ADDR_W-1:0] pc_load_addr_d;
    reg pc_load_d;
    reg [4:0] vector_offset_d;

    // slot to table offset; slots beyond the table keep their number
    function [4:0] slot_offset;
        input integer slot;
        begin
            case (slot)
                // external, pin-change and watchdog
                1: slot_offset = OFS_EXT0;
                2: slot_offset = OFS_EXT1;
                3: slot_offset = OFS_PC0;
                4: slot_offset = OFS_PC1;
                5: slot_offset = OFS_PC2;
                6: slot_offset = OFS_WDOG;

                // timer two
                7: slot_offset = OFS_T2_MA;
                8: slot_offset = OFS_T2_MB;
                9: slot_offset = OFS_T2_WRAP;

                // timer one
                10: slot_offset = OFS_T1_CAP;
                11: slot_offset = OFS_T1_MA;
                12: slot_offset = OFS_T1_MB;
                13: slot_offset = OFS_T1_WRAP;

                // timer zero
                14: slot_offset = OFS_T0_MA;
                15: slot_offset = OFS_T0_MB;
                16: slot_offset = OFS_T0_WRAP;

                // serial units
                17: slot_offset = OFS_SSER;
                18: slot_offset = OFS_ARX;
                19: slot_offset = OFS_ATXE;
                20: slot_offset = OFS_ATXC;

                // converter to program store
                21: slot_offset = OFS_CONV;
                22: slot_offset = OFS_NVM;
                23: slot_offset = OFS_ACMP;
                24: slot_offset = OFS_TWS;
                25: slot_offset = OFS_STORE;
                default: slot_offset = slot[4:0];
            endcase
        end
    endfunction

    // requests in the reset-load cycle are refused here
    // gating keeps enc_hit low while the reset load is pending
    generate
        for (g = 0; g < SRC_N; g = g + 1) begin : g_src
            localparam [4:0] SLOT = g + 1;
            assign src_live[g] = irq_accept[g] & (state_q == ST_RUN);
            if (g < `RIVM_SRC_N) begin : g_tab
                // only the selected slot feeds the or-tree
                assign tab_term[g*5 +: 5] = (enc_slot == SLOT) ? slot_offset(g + 1) : NO_OFFSET;
            end else begin : g_raw
                // past the table the slot number is the offset
                assign tab_term[g*5 +: 5] = (enc_slot == SLOT) ? SLOT : NO_OFFSET;
            end
        end
    endgenerate

    // offset follows source position
    // encoder only finds the slot; the table above gives the offset
    rivm_offset_enc #(
        .SRC_N(SRC_N)
    ) u_enc (
        .src(src_live),
        .offset(enc_slot),
        .hit(enc_hit)
    );

    // one term at most is nonzero, so a plain or picks it
    always @* begin
        tab_offset = NO_OFFSET;
        for (j = 0; j < SRC_N; j = j + 1) begin
            tab_offset = tab_offset | tab_term[j*5 +: 5];
        end
    end

    always @* begin
        if (boot_reset_vector_fuse == FUSE_PROG) begin
            reset_addr = boot_reset_addr;
        end else begin
            reset_addr = RESET_TARGET;
        end
    end

    // table moves with the select bit alone
    always @* begin
        if (vector_table_select) begin
            table_start = boot_reset_addr;
        end else begin
            table_start = RESET_TARGET;
        end
    end

    // reset load happens once, then only requests cause loads
    always @* begin
        case (state_q)
            ST_RESET: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = state_q;
            end
        endcase
    end

    // address and offset hold unless a load fires
    always @* begin
        pc_load_d = 1'b0;
        pc_load_addr_d = pc_load_addr_q;
        vector_offset_d = vector_offset_q;
        case (state_q)
            ST_RESET: begin
                // first cycle after release: jump to reset target
                pc_load_d = 1'b1;
                pc_load_addr_d = reset_addr;
                vector_offset_d = NO_OFFSET;
            end
            default: begin
                if (enc_hit) begin
                    pc_load_d = 1'b1;
                    pc_load_addr_d = table_start + {{(ADDR_W-5){1'b0}}, tab_offset};
                    vector_offset_d = tab_offset;
                end
            end
        endcase
    end

    // state and load pulse; async clear so the reset load waits for release
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RESET;
            pc_load_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_load_q <= pc_load_d;
        end
    end

    // address holds between loads for the core to fetch
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc_load_addr_q <= RESET_TARGET;
        end else begin
            pc_load_addr_q <= pc_load_addr_d;
        end
    end

    // offset of the last load, zero after a reset load
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vector_offset_q <= NO_OFFSET;
        end else begin
            vector_offset_q <= vector_offset_d;
        end
    end
endmodule // rivm_vector_map

`default_nettype wire

/* bench/rivm_chk.sv */
/* vector map port checker; bound to rivm_vector_map */
`timescale 1ns/1ns
`default_nettype none
module rivm_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic boot_reset_vector_fuse,
    input wire logic vector_table_select,
    input wire logic [11:0] boot_reset_addr,
    input wire logic [24:0] irq_accept,
    input wire logic [11:0] pc_load_addr_q,
    input wire logic pc_load_q,
    input wire logic [4:0] vector_offset_q
);
    logic up_q;
    logic go;
    function automatic logic [4:0] lo(input logic [24:0] v);
        lo = 5'h00;
        for (int i = 24; i >= 0; i--) if (v[i]) lo = 5'(i + 1);
    endfunction
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) up_q <= 1'b0;
        else up_q <= 1'b1;
    end
    assign go = up_q && |irq_accept;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rst; !up_q |=> pc_load_q && vector_offset_q == 5'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset load");
    property p_r0; !up_q && boot_reset_vector_fuse |=> pc_load_addr_q == 12'h000; endproperty
    a_r0: assert property (p_r0) else $error("reset addr");
    property p_rb; !up_q && !boot_reset_vector_fuse |=> pc_load_addr_q == $past(boot_reset_addr); endproperty
    a_rb: assert property (p_rb) else $error("boot reset");
    property p_ld; go |=> pc_load_q && vector_offset_q == $past(lo(irq_accept)); endproperty
    a_ld: assert property (p_ld) else $error("offset");
    property p_hi; go && vector_table_select |=> pc_load_addr_q == $past(boot_reset_addr) + $past(lo(irq_accept));
    endproperty
    a_hi: assert property (p_hi) else $error("boot table");
    property p_lo; go && !vector_table_select |=> pc_load_addr_q == 12'($past(lo(irq_accept))); endproperty
    a_lo: assert property (p_lo) else $error("base table");
    property p_idle; up_q && !go |=> !pc_load_q; endproperty
    a_idle: assert property (p_idle) else $error("spurious load");
    property p_hold; !pc_load_q |-> $stable(pc_load_addr_q) && $stable(vector_offset_q); endproperty
    a_hold: assert property (p_hold) else $error("not held");
    c_sel: cover property (go && vector_table_select);
    c_boot: cover property (!up_q && !boot_reset_vector_fuse);
    c_two: cover property (go && $countones(irq_accept) > 1);
endmodule // rivm_chk
bind rivm_vector_map rivm_chk u_chk (.*);
`default_nettype wire

/* bench/rivm_src.sv */
/* accepted-source model: registers the bench request into the accept vector one cycle later */
`timescale 1ns/1ns
`default_nettype none
module rivm_src (
    input wire logic clock,
    input wire logic [24:0] req,
    output logic [24:0] irq
);
    always @(posedge clock) irq <= req;
endmodule // rivm_src
`default_nettype wire

/* bench/testbench.sv */
/* vector map bench; drives reset, config and accepted sources */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clock = 1'b0, rst_n = 1'b0, fuse = 1'b1, sel = 1'b0;
    logic [11:0] bra = 12'hc00;
    logic [24:0] req = 25'h0000000, irq;
    int err_count = 0, total_checks = 0;
    rivm_src src (.clock(clock), .req(req), .irq(irq));
    rivm_vector_map dut (.clock(clock), .rst_n(rst_n), .boot_reset_vector_fuse(fuse),
        .vector_table_select(sel), .boot_reset_addr(bra), .irq_accept(irq),
        .pc_load_addr_q(), .pc_load_q(), .vector_offset_q());
    initial forever #20 clock = ~clock;
    task chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task t_rst(input logic f);
        @(posedge clock) rst_n <= 1'b0;
        fuse <= f;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock) #1;
        chk(dut.pc_load_q, 12'h001);
        chk(dut.pc_load_addr_q, f ? 12'h000 : bra);
        $display("reset test done");
    endtask
    task snd(input logic [24:0] r, input logic [4:0] k);
        @(posedge clock) req <= r;
        @(posedge clock) req <= 25'h0000000;
        @(posedge clock) #1;
        chk(dut.pc_load_q, 12'h001);
        chk(dut.vector_offset_q, 12'(k));
        chk(dut.pc_load_addr_q, (sel ? bra : 12'h000) + 12'(k));
        @(posedge clock) #1;
        chk(dut.pc_load_q, 12'h000);
    endtask
    task t_vec(input logic s);
        @(posedge clock) sel <= s;
        for (int k = 1; k <= 25; k++) snd(25'h0000001 << (k - 1), 5'(k));
        // two sources at once: lower index wins
        snd(25'h0000c00, 5'h0b);
        $display("vector test done");
    endtask
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
    initial begin
        t_rst(1'b1);
        t_vec(1'b1);
        t_rst(1'b0);
        t_vec(1'b0);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
